// ### shared/sbi_pkg.sv
// Shared constants, field layouts and types for the serial bus interface
package sbi_pkg;

  // Register selects seen by the register port
  typedef enum logic [2:0] {
    SEL_CTRL1,
    SEL_CTRL2,
    SEL_BUF,
    SEL_ADDR,
    SEL_RATE_A,
    SEL_RATE_B
  } sbi_sel_e;

  // Operating mode field encodings
  localparam logic [1:0] MODE_PORT = 2'h0;
  localparam logic [1:0] MODE_SIO = 2'h1;
  localparam logic [1:0] MODE_I2C = 2'h2;

  // First control register fields
  localparam int C1_BC_LSB = 5;
  localparam int C1_ACK_BIT = 4;
  localparam int C1_SCK_LSB = 0;

  // Second control register fields (write side)
  localparam int C2_MST_BIT = 7;
  localparam int C2_TRX_BIT = 6;
  localparam int C2_BB_BIT = 5;
  localparam int C2_PIN_BIT = 4;
  localparam int C2_MODE_LSB = 2;

  // Status fields, I2C view
  localparam int ST_MST_BIT = 7;
  localparam int ST_TRX_BIT = 6;
  localparam int ST_BB_BIT = 5;
  localparam int ST_PIN_BIT = 4;
  localparam int ST_AL_BIT = 3;
  localparam int ST_LRB_BIT = 0;
  // Status fields, synchronous serial view
  localparam int ST_SIO_BUSY_BIT = 3;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [1:0] MODE_RST = MODE_PORT;

  // Port-7 pin positions
  localparam int PIN_SCK = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SCL = 2;

  // Expected port-7 configuration per mode
  localparam logic [1:0] I2C_ODE = 2'h3;
  localparam logic [2:0] I2C_CFG_MASK = 3'h6;
  localparam logic [2:0] I2C_CFG = 3'h6;
  localparam logic [2:0] SIO_FUNC = 3'h7;
  localparam logic [1:0] SIO_DIR_HI = 2'h1;

  // Timing: quarter bit period in system clocks is QTR_BASE shifted by the divider field
  localparam logic [11:0] QTR_BASE = 12'h008;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef struct packed {
    logic [1:0] ode;   // Open-drain enables, bits 2..1
    logic [2:0] dir;   // Direction, bits 2..0
    logic [2:0] func;  // Function select, bits 2..0
  } sbi_port7_cfg_s;

endpackage : sbi_pkg

// ### logic/sbi_core.sv
// Serial bus interface: I2C master and clocked-synchronous 8-bit serial port
// Notes on behaviour
// - One channel that works either as a two-wire I2C port or as an 8-bit synchronous shifter.
// - In I2C mode pin 1 is open-drain data and pin 2 open-drain clock, with config 11/11X/11X.
// - In serial mode pin 0 is shift clock, pin 1 output, pin 2 input, function 111, direction 01X.
// - The same register places mean different things in I2C and in serial mode.
// - I2C supports start/stop framed, repeated-start and address-free byte streams.
// - Reading the second control register place returns status; that register is write-only.
module sbi_core
  import sbi_pkg::*;
(
  input wire logic clk_sys_i,                 // System clock
  input wire logic reset_n_i,                 // Synchronous reset, active low
  input wire sbi_sel_e reg_sel_i,             // Register select
  input wire logic reg_wr_i,                  // Write strobe
  input wire logic reg_rd_i,                  // Read strobe
  input wire logic [7:0] reg_wdata_i,         // Write data
  output logic [7:0] reg_rdata_o,             // Read data, valid cycle after strobe
  input wire sbi_port7_cfg_s port7_cfg_i,     // Port-7 configuration bits
  input wire logic [2:0] p7_in_i,             // Pin levels
  output logic [2:0] p7_out_o,                // Pin output values
  output logic [2:0] p7_oe_n_o,               // Pin output enables, low drives
  output logic busy_o                         // Transfer engine active
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP,
    ST_SIO_INT,
    ST_SIO_EXT
  } sbi_state_e;

  function automatic logic [11:0] quarter_len(input logic [2:0] div);
    quarter_len = QTR_BASE << div;
  endfunction : quarter_len

  // Bit count field of zero means a full byte
  function automatic logic [3:0] frame_bits(input logic [2:0] bc, input logic ack);
    frame_bits = ((bc == 3'h0) ? BYTE_BITS : {1'b0, bc}) + {3'h0, ack};
  endfunction : frame_bits

  sbi_state_e state;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [11:0] q_cnt;
  logic [7:0] ctrl1;
  logic [1:0] mode;
  logic mst;
  logic trx;
  logic bus_held;
  logic pend;
  logic arb_lost;
  logic lrb;
  logic [7:0] shift;
  logic [7:0] rx_byte;
  logic [7:0] own_addr;
  logic [7:0] rate_a;
  logic [7:0] rate_b;
  logic sda_q;
  logic scl_q;
  logic sck_q;
  logic so_q;
  logic [2:0] p7_meta;
  logic [2:0] p7_sync;
  logic sck_prev;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      p7_meta <= 3'h7;
      p7_sync <= 3'h7;
      sck_prev <= 1'b1;
    end
    else
    begin
      p7_meta <= p7_in_i;
      p7_sync <= p7_meta;
      sck_prev <= p7_sync[PIN_SCK];
    end
  end

  wire logic sda_in = p7_sync[PIN_SDA];
  wire logic scl_in = p7_sync[PIN_SCL];
  wire logic si_in = p7_sync[PIN_SCL];
  wire logic sck_rise = p7_sync[PIN_SCK] & ~sck_prev;
  wire logic sck_fall = ~p7_sync[PIN_SCK] & sck_prev;

  // Pins are only taken over when the port is configured for the mode
  wire logic i2c_mode = (mode == MODE_I2C);
  wire logic sio_mode = (mode == MODE_SIO);
  wire logic i2c_ok = i2c_mode & (port7_cfg_i.ode == I2C_ODE)
    & ((port7_cfg_i.dir & I2C_CFG_MASK) == I2C_CFG)
    & ((port7_cfg_i.func & I2C_CFG_MASK) == I2C_CFG);
  wire logic sio_ok = sio_mode & (port7_cfg_i.func == SIO_FUNC)
    & (port7_cfg_i.dir[2:1] == SIO_DIR_HI);
  wire logic sio_ext = ~port7_cfg_i.dir[PIN_SCK];

  wire logic [2:0] bc = ctrl1[C1_BC_LSB +: 3];
  wire logic ack_en = ctrl1[C1_ACK_BIT];
  wire logic [2:0] sck_div = ctrl1[C1_SCK_LSB +: 3];
  wire logic [3:0] last_bit = frame_bits(bc, ack_en) - 4'h1;
  wire logic data_bit = (bit_cnt < frame_bits(bc, 1'b0));

  wire logic wr_c1 = reg_wr_i & (reg_sel_i == SEL_CTRL1);
  wire logic wr_c2 = reg_wr_i & (reg_sel_i == SEL_CTRL2);
  wire logic wr_buf = reg_wr_i & (reg_sel_i == SEL_BUF);
  wire logic rd_buf = reg_rd_i & (reg_sel_i == SEL_BUF);
  wire logic idle = (state == ST_IDLE);

  // Clock stretching: the high phase waits until the line really is high
  // The line is released at the end of phase 1, so the wait belongs to phase 2
  wire logic wait_scl = (state == ST_START || state == ST_BIT || state == ST_STOP)
    && (phase == 2'h2);
  // Count runs 0 to Q-1 so that each quarter lasts exactly Q clocks
  wire logic q_top = (q_cnt == quarter_len(sck_div) - 12'h001);
  wire logic adv = q_top & (~wait_scl | scl_in);

  // Master transmitter losing the data line to another master
  wire logic lost_now = (state == ST_BIT) & adv & (phase == 2'h2) & trx & data_bit
    & sda_q & ~sda_in;
  wire logic end_i2c = (state == ST_BIT) & adv & (phase == 2'h3) & (bit_cnt == last_bit);
  wire logic end_sio_int = (state == ST_SIO_INT) & adv & (phase == 2'h3)
    & (bit_cnt == BYTE_BITS - 4'h1);
  wire logic end_sio_ext = (state == ST_SIO_EXT) & sck_rise & (bit_cnt == BYTE_BITS - 4'h1);
  wire logic set_pend = end_i2c | end_sio_int | end_sio_ext | lost_now;
  wire logic clr_pend = wr_buf | rd_buf | (wr_c2 & reg_wdata_i[C2_PIN_BIT]);

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      q_cnt <= 12'h000;
    end
    else if (idle || adv)
    begin
      q_cnt <= 12'h000;
    end
    else if (!q_top)
    begin
      q_cnt <= q_cnt + 12'h001;
    end
  end

  // Hardware event wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      pend <= 1'b0;
    end
    else if (set_pend)
    begin
      pend <= 1'b1;
    end
    else if (clr_pend)
    begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      ctrl1 <= CTRL1_RST;
      mode <= MODE_RST;
      mst <= 1'b0;
      trx <= 1'b0;
      own_addr <= ADDR_RST;
      rate_a <= RATE_RST;
      rate_b <= RATE_RST;
    end
    else
    begin
      if (wr_c1)
      begin
        ctrl1 <= reg_wdata_i;
      end
      // Mode is assumed to change only on a free bus with high pins
      if (wr_c2)
      begin
        mode <= reg_wdata_i[C2_MODE_LSB +: 2];
        mst <= reg_wdata_i[C2_MST_BIT];
        trx <= reg_wdata_i[C2_TRX_BIT];
      end
      else if (lost_now)
      begin
        mst <= 1'b0;
      end
      if (reg_wr_i && reg_sel_i == SEL_ADDR)
      begin
        own_addr <= reg_wdata_i;
      end
      if (reg_wr_i && reg_sel_i == SEL_RATE_A)
      begin
        rate_a <= reg_wdata_i;
      end
      if (reg_wr_i && reg_sel_i == SEL_RATE_B)
      begin
        rate_b <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state <= ST_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      bus_held <= 1'b0;
      arb_lost <= 1'b0;
      lrb <= 1'b0;
      shift <= BUF_RST;
      rx_byte <= BUF_RST;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
      sck_q <= 1'b1;
      so_q <= 1'b1;
    end
    else
    begin
      if (adv)
      begin
        phase <= phase + 2'h1;
      end
      case (state)
        ST_IDLE:
        begin
          phase <= 2'h0;
          bit_cnt <= 4'h0;
          if (wr_buf)
          begin
            shift <= reg_wdata_i;
            so_q <= reg_wdata_i[0];
          end
          if (wr_c2 && i2c_ok && reg_wdata_i[C2_MST_BIT])
          begin
            // Start and repeated start share one sequence; buffer holds the address
            if (reg_wdata_i[C2_BB_BIT])
            begin
              state <= ST_START;
              bus_held <= 1'b1;
              arb_lost <= 1'b0;
            end
            else if (bus_held)
            begin
              state <= ST_STOP;
            end
          end
          else if (wr_buf && i2c_ok && bus_held)
          begin
            state <= ST_BIT; // Address-free data bytes
          end
          else if (wr_buf && sio_ok)
          begin
            state <= sio_ext ? ST_SIO_EXT : ST_SIO_INT;
          end
        end
        ST_START:
        begin
          if (adv)
          begin
            case (phase)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              default:
              begin
                scl_q <= 1'b0;
                state <= ST_BIT;
              end
            endcase
          end
        end
        ST_BIT:
        begin
          if (lost_now)
          begin
            arb_lost <= 1'b1;
            bus_held <= 1'b0;
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            state <= ST_IDLE;
          end
          else if (adv)
          begin
            case (phase)
              2'h0: sda_q <= data_bit ? (trx ? shift[7] : 1'b1) : (trx | ~ack_en);
              2'h1: scl_q <= 1'b1;
              2'h2:
              begin
                if (data_bit)
                begin
                  shift <= {shift[6:0], sda_in};
                end
                else
                begin
                  lrb <= sda_in;
                end
              end
              default:
              begin
                scl_q <= 1'b0;
                bit_cnt <= bit_cnt + 4'h1;
                if (end_i2c)
                begin
                  rx_byte <= shift;
                  state <= ST_IDLE;
                end
              end
            endcase
          end
        end
        ST_STOP:
        begin
          if (adv)
          begin
            case (phase)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              default:
              begin
                bus_held <= 1'b0;
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_SIO_INT:
        begin
          // Byte goes out least significant bit first
          if (adv)
          begin
            case (phase)
              2'h0:
              begin
                sck_q <= 1'b0;
                so_q <= shift[0];
              end
              2'h2:
              begin
                sck_q <= 1'b1;
                shift <= {si_in, shift[7:1]};
              end
              2'h3:
              begin
                bit_cnt <= bit_cnt + 4'h1;
                if (end_sio_int)
                begin
                  rx_byte <= shift;
                  state <= ST_IDLE;
                end
              end
              default: sck_q <= 1'b0;
            endcase
          end
        end
        ST_SIO_EXT:
        begin
          if (sck_fall)
          begin
            so_q <= shift[0];
          end
          else if (sck_rise)
          begin
            shift <= {si_in, shift[7:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (end_sio_ext)
            begin
              rx_byte <= {si_in, shift[7:1]};
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Status uses the serial layout in serial mode and the I2C layout in every other mode
  wire logic [7:0] i2c_status = {mst, trx, bus_held, ~pend, arb_lost, 2'h0, lrb};
  wire logic [7:0] sio_status = {4'h0, ~idle, 3'h0};
  wire logic [7:0] status = sio_mode ? sio_status : i2c_status;
  wire logic [7:0] rd_mux = (reg_sel_i == SEL_CTRL1) ? ctrl1
    : (reg_sel_i == SEL_CTRL2) ? status
    : (reg_sel_i == SEL_BUF) ? rx_byte
    : (reg_sel_i == SEL_ADDR) ? own_addr
    : (reg_sel_i == SEL_RATE_A) ? rate_a
    : (reg_sel_i == SEL_RATE_B) ? rate_b
    : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= rd_mux;
    end
  end

  // Open-drain lines only ever pull low; release leaves the level to the pull-up
  assign p7_out_o = i2c_mode ? 3'h0 : {1'b0, so_q, sck_q};
  assign p7_oe_n_o[PIN_SCK] = ~(sio_ok & ~sio_ext);
  assign p7_oe_n_o[PIN_SDA] = i2c_mode ? ~(i2c_ok & ~sda_q) : ~sio_ok;
  assign p7_oe_n_o[PIN_SCL] = ~(i2c_ok & ~scl_q);
  assign busy_o = ~idle;

endmodule : sbi_core

// ### tb/sbi_checker.sv
// Port-level assertions for the serial bus interface
module sbi_checker
  import sbi_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire sbi_sel_e reg_sel_i, // Register select
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire sbi_port7_cfg_s port7_cfg_i, // Pin config
  input wire logic [2:0] p7_in_i, // Pin levels
  input wire logic [2:0] p7_out_o, // Pin values
  input wire logic [2:0] p7_oe_n_o, // Pin enables
  input wire logic busy_o // Engine busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q;
  logic [2:0] div_q;
  logic [9:0] busy_cnt;
  wire cfg_i2c = port7_cfg_i.ode == I2C_ODE && (port7_cfg_i.dir & I2C_CFG_MASK) == I2C_CFG
    && (port7_cfg_i.func & I2C_CFG_MASK) == I2C_CFG;
  wire cfg_sio = port7_cfg_i.func == SIO_FUNC && port7_cfg_i.dir[2:1] == SIO_DIR_HI;
  wire wr_c2 = reg_wr_i && reg_sel_i == SEL_CTRL2;
  wire sio_go = reg_wr_i && reg_sel_i == SEL_BUF && !busy_o && mode_q == MODE_SIO && cfg_sio;
  wire i2c_go = wr_c2 && reg_wdata_i[7] && reg_wdata_i[5] && reg_wdata_i[3:2] == MODE_I2C
    && !busy_o && cfg_i2c && div_q == 3'h0;
  // Mode and divider mirrors let the timing checks know which figure applies
  always_ff @(posedge clk_sys_i)
  begin
    busy_cnt <= busy_o ? busy_cnt + 10'h001 : 10'h000;
    if (!reset_n_i)
      mode_q <= MODE_RST;
    else if (wr_c2)
      mode_q <= reg_wdata_i[3:2];
    if (!reset_n_i)
      div_q <= 3'h0;
    else if (reg_wr_i && reg_sel_i == SEL_CTRL1)
      div_q <= reg_wdata_i[2:0];
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence start_seen;
    !p7_oe_n_o[PIN_SDA] && p7_oe_n_o[PIN_SCL];
  endsequence
  sequence scl_pulled;
    !p7_oe_n_o[PIN_SCL];
  endsequence
  chk_rst_idle: assert property ($rose(reset_n_i) |-> p7_oe_n_o == 3'h7 &&
    p7_out_o == 3'h3 && !busy_o && reg_rdata_o == 8'h00) else $error("not idle after reset");
  chk_scl_open: assert property (!p7_oe_n_o[PIN_SCL] |-> cfg_i2c &&
    !p7_out_o[PIN_SCL]) else $error("clock pin driven outside open-drain setup");
  chk_sda_pin: assert property (!p7_oe_n_o[PIN_SDA] |->
    (cfg_i2c && !p7_out_o[PIN_SDA]) || cfg_sio) else $error("data pin driven wrongly");
  chk_sck_cfg: assert property (!p7_oe_n_o[PIN_SCK] |->
    port7_cfg_i.func == SIO_FUNC && port7_cfg_i.dir == 3'h3) else $error("shift clock misdriven");
  chk_sio_start: assert property (sio_go |=> busy_o)
    else $error("buffer write did not start a transfer");
  chk_sio_len: assert property ($fell(busy_o) && mode_q == MODE_SIO &&
    port7_cfg_i.dir[0] && div_q == 3'h0 |-> busy_cnt >= 10'h0FF && busy_cnt <= 10'h104)
    else $error("serial byte length wrong");
  chk_status_view: assert property (reg_rd_i && reg_sel_i == SEL_CTRL2 &&
    mode_q == MODE_SIO |=> reg_rdata_o == {4'h0, $past(busy_o), 3'h0})
    else $error("status view wrong");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_i2c_start: assert property (i2c_go |-> ##[8:60] start_seen ##[1:20] scl_pulled)
    else $error("start condition missing");
endmodule : sbi_checker

bind sbi_core sbi_checker chk_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .port7_cfg_i(port7_cfg_i), .p7_in_i(p7_in_i),
  .p7_out_o(p7_out_o), .p7_oe_n_o(p7_oe_n_o), .busy_o(busy_o));

// ### tb/sbi_far_end.sv
// Far-side model: pull-ups, an acknowledging I2C receiver and a serial peer
module sbi_far_end
  import sbi_pkg::*;
(
  input wire logic [2:0] p7_out_i, // Block pin values
  input wire logic [2:0] p7_oe_n_i, // Block pin enables, low drives
  input wire logic i2c_i, // Board wired for I2C
  input wire logic sel_i, // Serial peer selected, loads reply on rise
  input wire logic ext_go_i, // Rise sends eight external clocks
  input wire logic [7:0] reply_i, // Serial reply byte
  output logic [2:0] pin_o, // Resolved pin levels
  output logic [7:0] sio_got_o, // Byte seen on serial out
  output logic [7:0] i2c_got_o // Byte seen on the data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_sck = 1'b1;
  logic ack = 1'b0;
  logic si_bit = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [3:0] bits = 4'h0;
  // Lines 1 and 2 have pull-ups; the peer lets SI go whenever it is deselected
  assign pin_o[0] = p7_oe_n_i[0] ? ext_sck : p7_out_i[0];
  assign pin_o[1] = (p7_oe_n_i[1] | p7_out_i[1]) & !(i2c_i & ack);
  assign pin_o[2] = (i2c_i || !sel_i) ? (p7_oe_n_i[2] | p7_out_i[2]) : si_bit;
  always @(posedge ext_go_i)
    repeat (8)
    begin
      #24 ext_sck = 1'b0;
      #24 ext_sck = 1'b1;
    end
  always @(posedge sel_i)
    sh = reply_i;
  always @(negedge pin_o[0])
    if (!i2c_i)
    begin
      si_bit = sh[0];
      sh = sh >> 1;
    end
  always @(posedge pin_o[0])
    if (!i2c_i)
      sio_got_o = {pin_o[1], sio_got_o[7:1]};
  always @(negedge pin_o[1])
    if (i2c_i && pin_o[2])
      bits = 4'h0;
  always @(posedge pin_o[2])
    if (i2c_i)
    begin
      if (bits < 4'h8)
        i2c_got_o = {i2c_got_o[6:0], pin_o[1]};
      bits = bits + 4'h1;
    end
  always @(negedge pin_o[2])
    if (i2c_i)
    begin
      ack = (bits == 4'h8);
      if (bits == 4'h9)
        bits = 4'h0;
    end
endmodule : sbi_far_end

// ### tb/tb_sbi_core.sv
// Self-checking bench for the serial bus interface
module tb_sbi_core;
  import sbi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  sbi_sel_e reg_sel_i = SEL_CTRL1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  sbi_port7_cfg_s port7_cfg_i = '0;
  logic [7:0] reg_rdata_o, reply = 8'h00, sio_got, i2c_got, tx, adr;
  logic [2:0] p7_in_i, p7_out_o, p7_oe_n_o;
  logic busy_o, rd_d = 1'b0, i2c_w = 1'b0, sel = 1'b0, ext_go = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  int failures = 0, checks = 0, cycles = 0, seed = 90926;
  sbi_sel_e sels[5] = '{SEL_BUF, SEL_CTRL1, SEL_ADDR, SEL_RATE_A, SEL_RATE_B};
  always #2.5 clk_sys_i = ~clk_sys_i;
  sbi_core dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .port7_cfg_i(port7_cfg_i), .p7_in_i(p7_in_i),
    .p7_out_o(p7_out_o), .p7_oe_n_o(p7_oe_n_o), .busy_o(busy_o));
  sbi_far_end far_u (.p7_out_i(p7_out_o), .p7_oe_n_i(p7_oe_n_o), .i2c_i(i2c_w), .sel_i(sel),
    .ext_go_i(ext_go), .reply_i(reply), .pin_o(p7_in_i), .sio_got_o(sio_got),
    .i2c_got_o(i2c_got));
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic reg_wr(input sbi_sel_e s, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_sel_i <= s;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  // The expected byte is noted with its mask; the monitor compares a cycle later
  task automatic reg_rd(input sbi_sel_e s, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys_i);
    reg_sel_i <= s;
    reg_rd_i <= 1'b1;
    exp_q.push_back({m, e & m});
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask : reg_rd
  task automatic wait_idle();
    repeat (3) @(posedge clk_sys_i);
    while (busy_o !== 1'b0)
      @(posedge clk_sys_i);
  endtask : wait_idle
  task automatic finish_test();
    $display("Counts: %0d checks, %0d failures", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_sys_i)
  begin
    rd_d <= reg_rd_i;
    cycles++;
    if (rd_d)
    begin
      note = exp_q.pop_front();
      check_byte(reg_rdata_o & note[15:8], note[7:0]);
    end
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (sels[i]) reg_rd(sels[i], 8'h00, 8'hFF);
    reg_rd(sbi_sel_e'(3'h7), 8'h00, 8'hFF);
    for (int i = 1; i < 5; i++)
    begin
      tx = 8'($random(seed));
      reg_wr(sels[i], tx);
      reg_rd(sels[i], tx, (i == 1) ? 8'hF7 : 8'hFF);
    end
    $display("test register reset and readback done");
    port7_cfg_i <= '{ode: 2'h0, dir: 3'h3, func: SIO_FUNC};
    check_byte({5'h00, p7_in_i}, 8'h07);
    reg_wr(SEL_CTRL1, 8'h00);
    reg_wr(SEL_CTRL2, {4'h0, MODE_SIO, 2'h0});
    reg_rd(SEL_CTRL2, 8'h00, 8'hFF);
    for (int m = 1; m >= 0; m--)
    begin
      port7_cfg_i.dir[0] <= m[0];
      tx = 8'($random(seed));
      reply <= 8'($random(seed));
      reg_wr(SEL_BUF, tx);
      // Select after the reply has settled, so the peer never loads a stale byte
      sel <= 1'b1;
      ext_go <= !m[0];
      reg_wr(SEL_BUF, ~tx);
      reg_rd(SEL_CTRL2, 8'h08, 8'hFF);
      wait_idle();
      sel <= 1'b0;
      ext_go <= 1'b0;
      reg_rd(SEL_BUF, reply, 8'hFF);
      check_byte(sio_got, tx);
      $display("test serial byte with internal clock %0d done", m);
    end
    // Pins are set up first so the serial output lets go before the mode changes
    port7_cfg_i <= '{ode: I2C_ODE, dir: 3'h6, func: 3'h6};
    i2c_w <= 1'b1;
    reg_wr(SEL_CTRL1, 8'h10);
    check_byte({5'h00, p7_in_i}, 8'h07);
    reg_wr(SEL_CTRL2, 8'h08);
    adr = {7'($random(seed)), 1'b0};
    reg_wr(SEL_BUF, adr);
    reg_wr(SEL_CTRL2, 8'hF8);
    wait_idle();
    reg_rd(SEL_CTRL2, 8'hE0, 8'hFF);
    check_byte(i2c_got, adr);
    tx = 8'($random(seed));
    reg_wr(SEL_BUF, tx);
    wait_idle();
    check_byte(i2c_got, tx);
    reg_wr(SEL_CTRL2, 8'hF8);
    wait_idle();
    reg_rd(SEL_CTRL2, 8'hE0, 8'hF1);
    // Receiving byte after a repeated start: nobody drives data, so all ones arrive
    reg_wr(SEL_CTRL2, 8'hB8);
    wait_idle();
    reg_rd(SEL_CTRL2, 8'hA0, 8'hF1);
    reg_rd(SEL_BUF, 8'hFF, 8'hFF);
    reg_wr(SEL_CTRL2, 8'hD8);
    wait_idle();
    reg_rd(SEL_CTRL2, 8'h00, 8'h20);
    reg_wr(SEL_CTRL2, 8'h00);
    repeat (4) @(posedge clk_sys_i);
    check_byte({5'h00, p7_oe_n_o}, 8'h07);
    $display("test I2C frames done");
    finish_test();
  end
endmodule : tb_sbi_core
